// *** hw/rdsm_cfg.svh ***
// constants for the rs-485 drive scan master
`ifndef RDSM_CFG_SVH
`define RDSM_CFG_SVH
`define RDSM_PORT_MODE_DRIVE   16'h0003
`define RDSM_MAX_DRIVE         6'h3f
`define RDSM_BCAST_ADDR        8'hff
`define RDSM_CMD_FREQ_REF      16'hfa01
`define RDSM_CMD_RUN_CMD       16'hfa00
`define RDSM_CMD_OPER_FREQ     16'hfd00
`define RDSM_CMD_OUT_TERM      16'hfe07
`define RDSM_ERR_NONE          16'h0000
`define RDSM_ERR_TIMEOUT       16'h0001
`define RDSM_STAT_IDLE         16'h0000
`define RDSM_STAT_BUSY         16'h0001
`define RDSM_STAT_DONE         16'h0002
`define RDSM_TIMEOUT_US        40
`define RDSM_CLK_MHZ           125
`define RDSM_TIMEOUT_CYC       (`RDSM_TIMEOUT_US * `RDSM_CLK_MHZ)
`endif

// *** hw/rdsm_master.sv ***
// rs-485 drive scan master sequencer
//
// Functional notes
// - runs only while port mode select word equals three.
// - drive numbers 0 to 63 accepted, others flag an error.
// - mode 0 writes freq reference and run command, reads freq and terminals.
// - mode 1 reads frequency and terminal status only.
// - mode 2 sends user read code to one drive, stores answer.
// - mode 3 sends user write code and data to one drive.
// - mode 4 broadcasts user write code and data to all drives.
// - modes 0 and 1 poll drive 0 up to operand, then wrap.
// - modes 2 and 3 target the operand drive only.
// - mode 4 ignores operand and uses broadcast address.
// - error word keeps lowest-numbered drive code, zero means none.
// - 64-bit health map, bit n set on good answer, cleared on error answer or timeout.
// - input low idles with output low; operand error sets flag.
// - on input drop, finish current exchange before stopping.
// - frequency values are binary integers in 0.01 Hz units.
`timescale 1ns/100ps
`include "rdsm_cfg.svh"
`default_nettype none
module rdsm_master (
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    input  wire logic                i_instr_in,
    input  wire logic [15:0]         i_port_mode_select_word,
    input  wire logic [15:0]         i_drive_num,
    input  wire logic [15:0]         i_op_mode,
    input  wire logic [15:0]         i_user_code,
    input  wire logic [15:0]         i_user_data,
    input  wire logic [15:0]         i_freq_ref,
    input  wire logic [15:0]         i_run_cmd,
    input  wire logic                i_err_flag_clr,
    input  wire logic                i_tx_ready,
    input  wire logic                i_rx_valid,
    input  wire rdsm_pkg::rdsm_resp_t i_rx_resp,
    output logic                     o_instr_out,
    output logic                     o_instruction_error_flag,
    output logic                     o_tx_valid,
    output rdsm_pkg::rdsm_frame_t    o_tx_frame,
    output logic [15:0]              o_exec_status,
    output logic [15:0]              o_comm_err,
    output logic [63:0]              o_health_map,
    output logic                     o_rd_valid,
    output logic [5:0]               o_rd_drive,
    output logic [1:0]               o_rd_slot,
    output logic [15:0]              o_rd_data
);
    import rdsm_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEND,
        ST_WAIT,
        ST_NEXT
    } rdsm_state_t;

    // ****************************************
    // decoding
    // ****************************************
    function automatic logic mode_ok(input logic [15:0] m);
        mode_ok = (m <= 16'h0004);
    endfunction

    function automatic logic is_scan(input rdsm_mode_t m);
        is_scan = (m == RDSM_MODE_EXCHANGE) || (m == RDSM_MODE_MONITOR);
    endfunction

    // ****************************************
    // operand check and run level
    // ****************************************
    logic        operand_ok;
    logic        enabled;
    assign operand_ok = mode_ok(i_op_mode) &&
                        ((i_op_mode == 16'(RDSM_MODE_BCAST)) ||
                         (i_drive_num <= {10'h000, `RDSM_MAX_DRIVE}));
    assign enabled    = i_instr_in && (i_port_mode_select_word == `RDSM_PORT_MODE_DRIVE);

    rdsm_state_t state_q;
    rdsm_mode_t  mode_q;
    logic [5:0]  drv_q;
    logic [5:0]  max_q;
    logic [1:0]  step_q;
    logic [16:0] tmo_q;
    logic [15:0] first_err_q;
    logic        err_seen_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_instr_out <= 1'b0;
        end else begin
            o_instr_out <= i_instr_in;
        end
    end

    // sticky error flag
    // set wins over clear so a fresh fault is never lost
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_instruction_error_flag <= 1'b0;
        end else if (enabled && !operand_ok) begin
            o_instruction_error_flag <= 1'b1;
        end else if (i_err_flag_clr) begin
            o_instruction_error_flag <= 1'b0;
        end
    end

    // ****************************************
    // frame builder
    // ****************************************
    rdsm_frame_t frame_d;
    always_comb begin
        frame_d = '0;
        frame_d.addr = {2'b00, drv_q};
        case (mode_q)
            RDSM_MODE_EXCHANGE: begin
                case (step_q)
                    2'd0: begin
                        frame_d.write = 1'b1;
                        frame_d.code  = `RDSM_CMD_FREQ_REF;
                        frame_d.data  = i_freq_ref;
                    end
                    2'd1: begin
                        frame_d.write = 1'b1;
                        frame_d.code  = `RDSM_CMD_RUN_CMD;
                        frame_d.data  = i_run_cmd;
                    end
                    2'd2: frame_d.code = `RDSM_CMD_OPER_FREQ;
                    default: frame_d.code = `RDSM_CMD_OUT_TERM;
                endcase
            end
            RDSM_MODE_MONITOR: begin
                frame_d.code = (step_q == 2'd0) ? `RDSM_CMD_OPER_FREQ : `RDSM_CMD_OUT_TERM;
            end
            RDSM_MODE_READ: begin
                frame_d.code = i_user_code;
            end
            RDSM_MODE_WRITE: begin
                frame_d.write = 1'b1;
                frame_d.code  = i_user_code;
                frame_d.data  = i_user_data;
            end
            default: begin
                frame_d.addr  = `RDSM_BCAST_ADDR;
                frame_d.write = 1'b1;
                frame_d.code  = i_user_code;
                frame_d.data  = i_user_data;
            end
        endcase
    end

    // ****************************************
    // sequencer
    // ****************************************
    logic last_step;
    logic last_drive;
    assign last_step  = (mode_q == RDSM_MODE_EXCHANGE) ? (step_q == 2'd3) :
                        (mode_q == RDSM_MODE_MONITOR)  ? (step_q == 2'd1) : 1'b1;
    assign last_drive = !is_scan(mode_q) || (drv_q == max_q);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            mode_q  <= RDSM_MODE_EXCHANGE;
            drv_q   <= 6'h00;
            max_q   <= 6'h00;
            step_q  <= 2'd0;
            tmo_q   <= 17'h00000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (enabled && operand_ok) begin
                        mode_q <= rdsm_mode_t'(i_op_mode[2:0]);
                        max_q  <= i_drive_num[5:0];
                        step_q <= 2'd0;
                        drv_q  <= is_scan(rdsm_mode_t'(i_op_mode[2:0])) ? 6'h00
                                                                         : i_drive_num[5:0];
                        state_q <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (i_tx_ready) begin
                        tmo_q   <= 17'h00000;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (i_rx_valid || (mode_q == RDSM_MODE_BCAST) ||
                        (tmo_q == 17'(`RDSM_TIMEOUT_CYC - 1))) begin
                        state_q <= ST_NEXT;
                    end else begin
                        tmo_q <= tmo_q + 17'h00001;
                    end
                end
                ST_NEXT: begin
                    if (!last_step) begin
                        step_q  <= step_q + 2'd1;
                        state_q <= ST_SEND;
                    end else begin
                        step_q <= 2'd0;
                        drv_q  <= last_drive ? (is_scan(mode_q) ? 6'h00 : drv_q)
                                             : drv_q + 6'h01;
                        state_q <= enabled ? ST_SEND : ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // link outputs
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_tx_valid <= 1'b0;
            o_tx_frame <= '0;
        end else begin
            o_tx_valid <= (state_q == ST_SEND) && !i_tx_ready;
            o_tx_frame <= frame_d;
        end
    end

    // ****************************************
    // results
    // ****************************************
    logic got_rx;
    logic timed_out;
    assign got_rx    = (state_q == ST_WAIT) && i_rx_valid && (mode_q != RDSM_MODE_BCAST);
    assign timed_out = (state_q == ST_WAIT) && !i_rx_valid && (mode_q != RDSM_MODE_BCAST) &&
                       (tmo_q == 17'(`RDSM_TIMEOUT_CYC - 1));

    // read data handed to the data table
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rd_valid <= 1'b0;
            o_rd_drive <= 6'h00;
            o_rd_slot  <= 2'd0;
            o_rd_data  <= 16'h0000;
        end else begin
            o_rd_valid <= got_rx && !i_rx_resp.err && !o_tx_frame.write;
            o_rd_drive <= drv_q;
            o_rd_slot  <= step_q;
            o_rd_data  <= i_rx_resp.data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_health_map <= 64'h0;
        end else if (got_rx) begin
            o_health_map[drv_q] <= !i_rx_resp.err;
        end else if (timed_out) begin
            o_health_map[drv_q] <= 1'b0;
        end
    end

    // lowest drive error kept
    // the word is refreshed once per scan pass, at its end, with that same pass's faults
    logic        fault;
    logic [15:0] fault_code;
    assign fault      = (got_rx && i_rx_resp.err) || timed_out;
    assign fault_code = timed_out ? `RDSM_ERR_TIMEOUT : i_rx_resp.err_code;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            first_err_q <= `RDSM_ERR_NONE;
            err_seen_q  <= 1'b0;
            o_comm_err  <= `RDSM_ERR_NONE;
        end else if (state_q == ST_NEXT && last_step && last_drive) begin
            o_comm_err  <= err_seen_q ? first_err_q : `RDSM_ERR_NONE;
            err_seen_q  <= 1'b0;
            first_err_q <= `RDSM_ERR_NONE;
        end else if (fault && !err_seen_q) begin
            err_seen_q  <= 1'b1;
            first_err_q <= fault_code;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_exec_status <= `RDSM_STAT_IDLE;
        end else if (state_q == ST_IDLE) begin
            o_exec_status <= `RDSM_STAT_IDLE;
        end else if (state_q == ST_NEXT && last_step && last_drive) begin
            o_exec_status <= `RDSM_STAT_DONE;
        end else if (o_exec_status == `RDSM_STAT_IDLE) begin
            o_exec_status <= `RDSM_STAT_BUSY;
        end
    end
endmodule
`default_nettype wire

// *** hw/rdsm_pkg.sv ***
// types for the rs-485 drive scan master
package rdsm_pkg;
    typedef enum logic [2:0] {
        RDSM_MODE_EXCHANGE,
        RDSM_MODE_MONITOR,
        RDSM_MODE_READ,
        RDSM_MODE_WRITE,
        RDSM_MODE_BCAST
    } rdsm_mode_t;

    // one frame toward the drives
    typedef struct packed {
        logic [7:0]  addr;
        logic        write;
        logic [15:0] code;
        logic [15:0] data;
    } rdsm_frame_t;

    // one answer from a drive
    typedef struct packed {
        logic        err;
        logic [15:0] err_code;
        logic [15:0] data;
    } rdsm_resp_t;
endpackage

// *** tb/rdsm_chk.sv ***
// assertions for the drive scan master
`timescale 1ns/100ps
`default_nettype none
module rdsm_chk (
    input wire logic                  i_clk,
    input wire logic                  i_rst,
    input wire logic                  i_instr_in,
    input wire logic [15:0]           i_port_mode_select_word,
    input wire logic [15:0]           i_drive_num,
    input wire logic [15:0]           i_op_mode,
    input wire logic                  i_err_flag_clr,
    input wire logic                  i_tx_ready,
    input wire logic                  o_instr_out,
    input wire logic                  o_instruction_error_flag,
    input wire logic                  o_tx_valid,
    input wire rdsm_pkg::rdsm_frame_t o_tx_frame,
    input wire logic                  o_rd_valid,
    input wire logic [5:0]            o_rd_drive
);
    import rdsm_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_take;
        o_tx_valid && i_tx_ready;
    endsequence
    // mode 4 with a wild operand is left alone: operand ignored there
    sequence s_bad;
        i_instr_in && i_port_mode_select_word == 16'h3
            && (i_op_mode > 16'h4 || (i_op_mode < 16'h4 && i_drive_num > 16'h3f));
    endsequence
    port_sel_a: assert property (o_tx_valid |-> i_port_mode_select_word == 16'h3)
        else $error("frame sent while port not in drive mode");
    addr_range_a: assert property (o_tx_valid && o_tx_frame.addr != 8'hff
        |-> o_tx_frame.addr <= 8'h3f) else $error("drive number above 63");
    monitor_only_a: assert property (o_tx_valid && i_op_mode == 16'h1
        |-> !o_tx_frame.write) else $error("write sent in monitor mode");
    bcast_addr_a: assert property (s_take |-> i_op_mode != 16'h4
        || (o_tx_frame.addr == 8'hff && o_tx_frame.write)) else $error("bad broadcast");
    op_err_a: assert property (s_bad |=> o_instruction_error_flag)
        else $error("operand error not flagged");
    flag_sticky_a: assert property (o_instruction_error_flag && !i_err_flag_clr
        |=> o_instruction_error_flag) else $error("error flag dropped");
    instr_echo_a: assert property (1 |=> o_instr_out == $past(i_instr_in))
        else $error("output does not follow input");
    one_block_transfer_instruction_a: assert property (s_take |=> !o_tx_valid [*2])
        else $error("frame offered again while waiting");
    rd_target_a: assert property (o_rd_valid && i_op_mode == 16'h2
        |-> o_rd_drive == i_drive_num[5:0]) else $error("answer from wrong drive");
endmodule
bind rdsm_master rdsm_chk rdsm_chk_inst (.i_clk, .i_rst, .i_instr_in,
    .i_port_mode_select_word, .i_drive_num, .i_op_mode, .i_err_flag_clr, .i_tx_ready,
    .o_instr_out, .o_instruction_error_flag, .o_tx_valid, .o_tx_frame, .o_rd_valid,
    .o_rd_drive);
`default_nettype wire

// *** tb/rdsm_drive_model.sv ***
// behavioural drive on the far side of the link
`timescale 1ns/100ps
`default_nettype none
module rdsm_drive_model (
    input  wire logic                  i_clk,
    input  wire logic                  i_tx_valid,
    input  wire rdsm_pkg::rdsm_frame_t i_tx_frame,
    input  wire logic [6:0]            i_bad_from,
    input  wire logic                  i_slow,
    input  wire logic                  i_mute,
    output logic                       o_tx_ready,
    output logic                       o_rx_valid,
    output rdsm_pkg::rdsm_resp_t       o_rx_resp
);
    import rdsm_pkg::*;
    rdsm_frame_t f_q;
    logic        busy_q;
    int          cnt_q;
    initial begin
        o_tx_ready = 0;
        o_rx_valid = 0;
        o_rx_resp = '0;
        busy_q = 0;
    end
    always @(posedge i_clk) begin
        o_tx_ready <= i_tx_valid && !o_tx_ready && !busy_q;
        o_rx_valid <= 1'b0;
        // released answer lines toggle, never hold the last word
        if (o_rx_valid) o_rx_resp <= ~o_rx_resp;
        if (i_tx_valid && o_tx_ready) begin
            f_q <= i_tx_frame;
            busy_q <= i_tx_frame.addr != 8'hff;
            cnt_q <= i_slow ? 40 : 1;
        end else if (busy_q && cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
        end else if (busy_q) begin
            busy_q <= 1'b0;
            // a muted drive swallows the frame and never answers
            o_rx_valid <= !i_mute;
            o_rx_resp.err <= {1'b0, f_q.addr[5:0]} >= i_bad_from;
            o_rx_resp.err_code <= 16'h00a0 + {10'h0, f_q.addr[5:0]};
            o_rx_resp.data <= {f_q.addr, f_q.code[7:0]};
        end
    end
endmodule
`default_nettype wire

// *** tb/tb_rdsm_master.sv ***
// self-checking bench for the drive scan master
`timescale 1ns/100ps
`default_nettype none
module tb_rdsm_master;
    import rdsm_pkg::*;
    logic        clk, rst, instr, clr, rdy, rxv, txv, iout, eflag, rdv, slow, mute;
    logic [15:0] pm, dn, om, uc, ud, fr, rc, est, cerr, rdd, rdl;
    logic [63:0] hmap;
    logic [5:0]  rdr;
    logic [1:0]  rds;
    logic [7:0]  rdw;
    logic [6:0]  badf;
    rdsm_resp_t  resp;
    rdsm_frame_t frm;
    rdsm_frame_t fq[$];
    int          n_mismatch;
    int          num_checks;
    rdsm_master rdsm_master_inst (.i_clk(clk), .i_rst(rst), .i_instr_in(instr),
        .i_port_mode_select_word(pm), .i_drive_num(dn), .i_op_mode(om), .i_user_code(uc),
        .i_user_data(ud), .i_freq_ref(fr), .i_run_cmd(rc), .i_err_flag_clr(clr),
        .i_tx_ready(rdy), .i_rx_valid(rxv), .i_rx_resp(resp), .o_instr_out(iout),
        .o_instruction_error_flag(eflag), .o_tx_valid(txv), .o_tx_frame(frm),
        .o_exec_status(est), .o_comm_err(cerr), .o_health_map(hmap), .o_rd_valid(rdv),
        .o_rd_drive(rdr), .o_rd_slot(rds), .o_rd_data(rdd));
    rdsm_drive_model rdsm_drive_model_inst (.i_clk(clk), .i_tx_valid(txv), .i_tx_frame(frm),
        .i_bad_from(badf), .i_slow(slow), .i_mute(mute), .o_tx_ready(rdy), .o_rx_valid(rxv),
        .o_rx_resp(resp));
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) if (txv && rdy) fq.push_back(frm);
    always @(posedge clk) if (rdv) rdl <= rdd;
    always @(posedge clk) if (rdv) rdw <= {rds, rdr};
    task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic restart(logic [15:0] m, logic [15:0] d);
        rst = 1; instr = 0; slow = 0; mute = 0; om = m; dn = d; fq.delete(); cyc(6); rst = 0;
    endtask
    task automatic t_reset();
        restart(0, 0);
        chk("reset status", {est, cerr}, 0);
        chk("reset map", hmap, 0);
        chk("reset flags", {eflag, txv, iout}, 0);
    endtask
    // frame heads are judged, frame data on writes only; read data is the drive's, not ours
    task automatic t_scan(logic [15:0] m, logic [15:0] n, logic [6:0] b, int nf,
                          logic [63:0] eh, logic [15:0] ec);
        int st, d, j;
        logic wr;
        logic [15:0] cd[4];
        cd = '{16'hfa01, 16'hfa00, 16'hfd00, 16'hfe07};
        restart(m, n); badf = b; instr = 1;
        for (int w = 0; w < 5000 && fq.size() < nf; w++) cyc(1);
        // status falls back to idle once stopped, so judge it while running
        chk("exec status", est, 16'h2);
        instr = 0; cyc(200);
        st = m == 0 ? 4 : m == 1 ? 2 : 1;
        chk("frame count", fq.size() >= nf, 1);
        for (int k = 0; k < nf && k < fq.size(); k++) begin
            j = m == 1 ? k % st + 2 : k % st;
            d = m < 2 ? (k / st) % (n + 1) : n;
            wr = m == 0 ? j < 2 : m > 2;
            chk("frame head", {fq[k].addr, fq[k].write, fq[k].code},
                {m == 4 ? 8'hff : 8'(d), wr, m > 1 ? uc : cd[j]});
            if (wr) chk("frame data", fq[k].data, m == 0 ? (j == 0 ? fr : rc) : ud);
        end
        chk("health map", hmap, eh);
        chk("comm error", cerr, ec);
        if (m < 2) chk("last read", rdw, {m == 0 ? 2'd3 : 2'd1, 6'(d)});
    endtask
    task automatic t_drop();
        restart(2, 5); slow = 1; rdl = 0; instr = 1;
        for (int w = 0; w < 500 && fq.size() < 1; w++) cyc(1);
        chk("busy status", est, 16'h1);
        instr = 0; cyc(100);
        chk("read head", {fq[0].addr, fq[0].write, fq[0].code}, {8'h05, 1'b0, uc});
        chk("read data", rdl, 16'h0503);
        chk("stop after answer", fq.size(), 1);
        chk("target health", hmap, 64'h20);
        chk("read source", rdw, {2'd0, 6'd5});
        chk("idle status", est, 16'h0);
    endtask
    // drive answers once, then goes quiet
    task automatic t_silent();
        restart(2, 3); instr = 1;
        for (int w = 0; w < 100 && fq.size() < 2; w++) cyc(1);
        mute = 1;
        chk("answered map", hmap, 64'h8);
        for (int w = 0; w < 6000 && fq.size() < 3; w++) cyc(1);
        instr = 0;
        chk("moves on", fq.size(), 3);
        chk("silent map", hmap, 0);
        chk("silence code", cerr, 16'h0001);
    endtask
    task automatic t_refuse();
        restart(5, 1); instr = 1; cyc(3);
        chk("bad mode flag", eflag, 1);
        clr = 1; cyc(1);
        chk("set beats clear", eflag, 1);
        instr = 0; cyc(2); clr = 0;
        chk("flag cleared", eflag, 0);
        om = 1; dn = 64; instr = 1; cyc(3);
        chk("bad drive flag", eflag, 1);
        instr = 0; clr = 1; cyc(2); clr = 0;
        pm = 2; dn = 1; instr = 1; cyc(30);
        chk("no frame off mode", fq.size(), 0);
        chk("out high", iout, 1);
        instr = 0; pm = 3; cyc(2);
        om = 4; dn = 16'h0040; instr = 1; cyc(20);
        chk("wild operand ignored", eflag, 0);
        chk("bcast sent", fq.size() > 0 && fq[0].addr == 8'hff, 1);
        instr = 0; cyc(10);
    endtask
    initial begin
        rst = 1; instr = 0; clr = 0; slow = 0; mute = 0; pm = 16'h3; dn = 0; om = 0;
        uc = 16'hfe03;
        ud = 16'h0064; fr = 16'h0bb8; rc = 16'hc400; badf = 7'h40; rdl = 0;
        n_mismatch = 0; num_checks = 0;
        t_reset();
        t_scan(0, 2, 7'h01, 16, 64'h1, 16'h00a1);
        t_scan(1, 2, 7'h40, 8, 64'h7, 16'h0);
        t_scan(3, 63, 7'h40, 2, 64'h8000_0000_0000_0000, 16'h0);
        t_scan(4, 7, 7'h40, 2, 64'h0, 16'h0);
        t_drop();
        t_silent();
        t_refuse();
        print_verdict();
    end
    // whole run needs about six thousand cycles; allow 80000
    initial begin
        #640000;
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
